// >>> inc/pcg_consts.vh
// Constants for the peripheral clock gate and soft reset block
// Functional notes
// R01: A set gating bit clocks its unit; a clear bit leaves it unclocked.
// R02: Access to a unit whose clock is gated off answers with a bus fault.
// R03: All gating enables read zero after reset; units start unclocked.
// R04: Software enables each used unit's gating bit before touching it.
// R05: Run, sleep and deep-sleep gating registers apply per power state.
// R06: Sleep gating sets apply only when automatic gating is set.
// R07: Deep-sleep gating holds port A..H enables at bits 7:0, rest zero.
// R08: Reset register writes are masked by paired capability register bits.
// R09: Reset register 0 at 0x040: CAN bit 24, watchdog bit 3.
// R10: Reset register 1 at 0x044: comparators 25:24, timers 18:16, bits 4, 0.
// R11: Reset register 2 at 0x048: port A..H resets at bits 7:0.
// R12: All software reset registers reset to zero.
// R13: A set reset bit holds its unit in reset; clearing releases it.
// R14: Software preserves reserved bits on read-modify-write.
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH
`define PCG_OFS_SRC0      12'h040
`define PCG_OFS_SRC1      12'h044
`define PCG_OFS_SRC2      12'h048
`define PCG_OFS_RUN_GATE  12'h108
`define PCG_OFS_SLP_GATE  12'h118
`define PCG_OFS_DSL_GATE  12'h128
`define PCG_OFS_RUN_CFG   12'h060
`define PCG_OFS_IRQ_STAT  12'h200
`define PCG_OFS_IRQ_MASK  12'h204
`define PCG_OFS_FAULT_ADR 12'h208
`define PCG_SRC0_MASK     32'h01000008
`define PCG_SRC1_MASK     32'h03070011
`define PCG_SRC2_MASK     32'h000000ff
`define PCG_GATE_MASK     32'h000000ff
`define PCG_AUTO_GATE_BIT 27
`define PCG_RESET_VAL     32'h00000000
`define PCG_IRQ_FAULT     0
`define PCG_IRQ_UNMAPPED  1
`define PCG_IRQ_MASK_W    32'h00000003
`endif

// >>> logic/pcg_sync3.v
// Three-stage synchroniser with agreement of the last two stages
module pcg_sync3
(
  input  wire sys_clk,
  input  wire rst_n,
  input  wire clk_en,
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end
    else if (clk_en)
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Filters a one-cycle glitch out of the second stage
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule

// >>> logic/pcg_top.v
// Peripheral clock gating and software reset control with Avalon slave
`include "pcg_consts.vh"
module pcg_top
(
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire [11:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire        sleep_req,
  input  wire        deep_sleep_req,
  input  wire [31:0] capability_reg_1,
  input  wire [31:0] capability_reg_2,
  input  wire [31:0] capability_reg_4,
  input  wire        periph_access,
  input  wire [2:0]  periph_port_sel,
  output reg         periph_fault,
  output wire [7:0]  port_clk_en,
  output wire [31:0] soft_reset_0,
  output wire [31:0] soft_reset_1,
  output wire [31:0] soft_reset_2,
  output wire        irq
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RESP = 2'b10;

  localparam PWR_RUN   = 3'b001;
  localparam PWR_SLEEP = 3'b010;
  localparam PWR_DEEP  = 3'b100;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [31:0] src0_reg;
  reg  [31:0] src1_reg;
  reg  [31:0] src2_reg;
  reg  [7:0]  run_gate_reg;
  reg  [7:0]  slp_gate_reg;
  reg  [7:0]  dsl_gate_reg;
  reg         auto_gate_reg;
  reg  [1:0]  irq_stat_reg;
  reg  [1:0]  irq_mask_reg;
  reg  [2:0]  fault_port_reg;
  reg  [7:0]  gate_sel;
  reg  [31:0] rd_next;
  reg         hit_next;
  reg  [2:0]  pwr_state;
  reg  [31:0] rdata_next;
  reg  [1:0]  resp_next;
  reg  [31:0] src0_next;
  reg  [31:0] src1_next;
  reg  [31:0] src2_next;
  reg  [7:0]  run_gate_next;
  reg  [7:0]  slp_gate_next;
  reg  [7:0]  dsl_gate_next;
  reg         auto_gate_next;
  reg  [1:0]  irq_mask_next;
  reg  [1:0]  irq_stat_next;
  wire        stat_clr;
  wire [31:0] wmask;
  wire [31:0] wdata_be;
  wire        req;
  wire        wr_go;
  wire        sleep_s;
  wire        dsleep_s;
  wire        fault_ev;
  wire        unmapped_ev;
  wire [1:0]  ev_bits;

  // Power-state requests come from the power manager, off this clock
  pcg_sync3 u_sync_sleep
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .din     (sleep_req),
    .dout    (sleep_s)
  );

  pcg_sync3 u_sync_dsleep
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .din     (deep_sleep_req),
    .dout    (dsleep_s)
  );

  // Power state seen by the gating; deep sleep outranks sleep
  always @*
  begin
    pwr_state = PWR_RUN;
    if (auto_gate_reg && dsleep_s)                              // see R06
      pwr_state = PWR_DEEP;
    else if (auto_gate_reg && sleep_s)                          // see R06
      pwr_state = PWR_SLEEP;
  end

  // Gating set chosen by power state
  always @*
  begin
    case (pwr_state)
      PWR_DEEP:
        gate_sel = dsl_gate_reg;                                // see R05
      PWR_SLEEP:
        gate_sel = slp_gate_reg;                                // see R05
      PWR_RUN:
        gate_sel = run_gate_reg;                                // see R05
      default:
        gate_sel = run_gate_reg;
    endcase
  end

  assign port_clk_en = gate_sel;                                // see R01

  // Reset outputs held while the bit is one
  assign soft_reset_0 = src0_reg;                               // see R13
  assign soft_reset_1 = src1_reg;                               // see R13
  assign soft_reset_2 = src2_reg;                               // see R13

  // Gated port access faults instead of completing
  assign fault_ev = clk_en & periph_access &
                    ~gate_sel[periph_port_sel];                 // see R02

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      periph_fault   <= 1'b0;
      fault_port_reg <= 3'h0;
    end
    else if (clk_en)
    begin
      periph_fault <= fault_ev;                                 // see R02
      if (fault_ev)
        fault_port_reg <= periph_port_sel;
    end
  end

  // Bus side: one wait cycle, answer in ST_RESP
  assign req = avs_read | avs_write;
  // Frozen clock enable holds the answer back, else the write is lost
  assign avs_waitrequest = ~(clk_en & (state_reg == ST_RESP));
  assign wr_go = clk_en & avs_write & (state_reg == ST_RESP);
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata_be = avs_writedata & wmask;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (req)
          state_next = ST_RESP;
      ST_RESP:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @*
  begin
    hit_next = 1'b1;
    rd_next  = `PCG_RESET_VAL;
    case (avs_address)
      `PCG_OFS_SRC0:      rd_next = src0_reg;
      `PCG_OFS_SRC1:      rd_next = src1_reg;
      `PCG_OFS_SRC2:      rd_next = src2_reg;
      `PCG_OFS_RUN_GATE:  rd_next = {24'h000000, run_gate_reg};
      `PCG_OFS_SLP_GATE:  rd_next = {24'h000000, slp_gate_reg};
      `PCG_OFS_DSL_GATE:  rd_next = {24'h000000, dsl_gate_reg}; // see R07
      `PCG_OFS_RUN_CFG:   rd_next = {4'h0, auto_gate_reg, 27'h0};
      `PCG_OFS_IRQ_STAT:  rd_next = {30'h0, irq_stat_reg};
      `PCG_OFS_IRQ_MASK:  rd_next = {30'h0, irq_mask_reg};
      `PCG_OFS_FAULT_ADR: rd_next = {29'h0, fault_port_reg};
      default:            hit_next = 1'b0;
    endcase
  end

  assign unmapped_ev = clk_en & req & (state_reg == ST_RESP) & ~hit_next;
  assign ev_bits = {unmapped_ev, fault_ev};

  // Answer captured at the edge that enters ST_RESP, one cycle before it is taken, and held until the next request
  always @*
  begin
    rdata_next = avs_readdata;
    resp_next  = avs_response;
    if (state_reg == ST_IDLE && req)
    begin
      rdata_next = avs_read ? rd_next : 32'h00000000;
      resp_next  = hit_next ? 2'b00 : 2'b11;
    end
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= ST_IDLE;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'b00;
    end
    else if (clk_en)
    begin
      state_reg    <= state_next;
      avs_readdata <= rdata_next;
      avs_response <= resp_next;
    end
  end

  // Register writes: next values, then one clocked copy under clk_en
  always @*
  begin
    src0_next      = src0_reg;
    src1_next      = src1_reg;
    src2_next      = src2_reg;
    run_gate_next  = run_gate_reg;
    slp_gate_next  = slp_gate_reg;
    dsl_gate_next  = dsl_gate_reg;
    auto_gate_next = auto_gate_reg;
    irq_mask_next  = irq_mask_reg;
    if (wr_go)
    begin
      case (avs_address)
        `PCG_OFS_SRC0:
          src0_next = (src0_reg & ~(wmask & capability_reg_1)) |
                      (wdata_be & capability_reg_1 &
                       `PCG_SRC0_MASK);                         // see R08 R09
        `PCG_OFS_SRC1:
          src1_next = (src1_reg & ~(wmask & capability_reg_2)) |
                      (wdata_be & capability_reg_2 &
                       `PCG_SRC1_MASK);                         // see R08 R10
        `PCG_OFS_SRC2:
          src2_next = (src2_reg & ~(wmask & capability_reg_4)) |
                      (wdata_be & capability_reg_4 &
                       `PCG_SRC2_MASK);                         // see R08 R11
        `PCG_OFS_RUN_GATE:
          if (avs_byteenable[0])
            run_gate_next = avs_writedata[7:0];
        `PCG_OFS_SLP_GATE:
          if (avs_byteenable[0])
            slp_gate_next = avs_writedata[7:0];
        `PCG_OFS_DSL_GATE:
          if (avs_byteenable[0])
            dsl_gate_next = avs_writedata[7:0];                 // see R07
        `PCG_OFS_RUN_CFG:
          if (avs_byteenable[3])
            auto_gate_next = avs_writedata[`PCG_AUTO_GATE_BIT]; // see R06
        `PCG_OFS_IRQ_MASK:
          if (avs_byteenable[0])
            irq_mask_next = avs_writedata[1:0];
        // Unmapped and read-only offsets keep every register except irq_stat_reg, where an unmapped one sets bit 1
        default:
          irq_mask_next = irq_mask_reg;
      endcase
    end
  end

  // Write-one-to-clear strobe for the status register
  assign stat_clr = wr_go & (avs_address == `PCG_OFS_IRQ_STAT) &
                    avs_byteenable[0];

  // Sticky status; a new event wins over a same-cycle clear
  always @*
  begin
    irq_stat_next = irq_stat_reg | ev_bits;
    if (stat_clr)
      irq_stat_next = (irq_stat_reg & ~avs_writedata[1:0]) | ev_bits;
  end

  // Software-visible registers
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src0_reg      <= `PCG_RESET_VAL;                          // see R12
      src1_reg      <= `PCG_RESET_VAL;                          // see R12
      src2_reg      <= `PCG_RESET_VAL;                          // see R12
      run_gate_reg  <= 8'h00;                                   // see R03
      slp_gate_reg  <= 8'h00;                                   // see R03
      dsl_gate_reg  <= 8'h00;                                   // see R03
      auto_gate_reg <= 1'b0;
      irq_mask_reg  <= 2'b00;
      irq_stat_reg  <= 2'b00;
    end
    else if (clk_en)
    begin
      src0_reg      <= src0_next;
      src1_reg      <= src1_next;
      src2_reg      <= src2_next;
      run_gate_reg  <= run_gate_next;
      slp_gate_reg  <= slp_gate_next;
      dsl_gate_reg  <= dsl_gate_next;
      auto_gate_reg <= auto_gate_next;
      irq_mask_reg  <= irq_mask_next;
      irq_stat_reg  <= irq_stat_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// >>> verification/pcg_top_assertions.sv
// Port assertions for the clock gate and soft reset block
`include "pcg_consts.vh"
module pcg_top_assertions
(
  input wire        sys_clk,
  input wire        rst_n,
  input wire        clk_en,
  input wire [11:0] avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [1:0]  avs_response,
  input wire [31:0] capability_reg_1,
  input wire [31:0] capability_reg_2,
  input wire [31:0] capability_reg_4,
  input wire        periph_access,
  input wire [2:0]  periph_port_sel,
  input wire        periph_fault,
  input wire [7:0]  port_clk_en,
  input wire [31:0] soft_reset_0,
  input wire [31:0] soft_reset_1,
  input wire [31:0] soft_reset_2
);
  wire [95:0] src = {soft_reset_2, soft_reset_1, soft_reset_0};
  wire [95:0] cap = {capability_reg_4, capability_reg_2, capability_reg_1};
  wire        ans = !avs_waitrequest;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_ans;
    clk_en && (avs_read || avs_write) && !ans |=> ans || !clk_en;
  endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_fault;
    clk_en && periph_access
    |=> periph_fault != $past(port_clk_en[periph_port_sel]);
  endproperty
  a_fault: assert property (p_fault) else $error("fault wrong");
  property p_nofault;
    clk_en && !periph_access |=> !periph_fault;
  endproperty
  a_nofault: assert property (p_nofault) else $error("stray");
  property p_res;
    ((soft_reset_0 & ~`PCG_SRC0_MASK) | (soft_reset_1 & ~`PCG_SRC1_MASK)
     | (soft_reset_2 & ~`PCG_SRC2_MASK)) == 32'h0;
  endproperty
  a_res: assert property (p_res) else $error("reserved set");
  property p_cap; ((src ^ $past(src)) & ~$past(cap)) == 96'h0; endproperty
  a_cap: assert property (p_cap) else $error("absent bit moved");
  property p_chg; src != $past(src) |-> $past(avs_write && ans); endproperty
  a_chg: assert property (p_chg) else $error("reset moved");
  property p_rst; $rose(rst_n) |-> port_clk_en == 8'h0 && src == 96'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("not cleared");
  property p_rd0;
    avs_read && ans && avs_address == `PCG_OFS_SRC0
    |-> (avs_readdata & ~`PCG_SRC0_MASK) == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("reserved read");
  c_fault: cover property (periph_fault);
  c_unmapped: cover property (ans && avs_response == 2'h3);
  c_clocked: cover property (port_clk_en != 8'h0 && ans);
endmodule

bind pcg_top pcg_top_assertions u_chk
(
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .capability_reg_1(capability_reg_1), .capability_reg_2(capability_reg_2),
  .capability_reg_4(capability_reg_4), .periph_access(periph_access),
  .periph_port_sel(periph_port_sel), .periph_fault(periph_fault),
  .port_clk_en(port_clk_en), .soft_reset_0(soft_reset_0),
  .soft_reset_1(soft_reset_1), .soft_reset_2(soft_reset_2)
);

// >>> verification/pcg_top_tb.sv
// Self-checking bench for the clock gate and soft reset block
`include "pcg_consts.vh"
module pcg_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [11:0] avs_address = 12'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic        clk_en = 1'h1;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] capability_reg_1 = 32'hffffffff;
  logic [31:0] capability_reg_2 = 32'hffffffff;
  logic [31:0] capability_reg_4 = 32'hffffffff;
  logic        sleep_req = 1'h0;
  logic        deep_sleep_req = 1'h0;
  logic        periph_access = 1'h0;
  logic [2:0]  periph_port_sel = 3'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire  [1:0]  avs_response;
  wire         periph_fault;
  wire  [7:0]  port_clk_en;
  wire  [31:0] soft_reset_0;
  wire  [31:0] soft_reset_1;
  wire  [31:0] soft_reset_2;
  wire         irq;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          miscompares = 0;
  int          compares = 0;
  int          cyc = 0;
  pcg_top uut
  (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .clk_en           (clk_en),
    .avs_address      (avs_address),
    .avs_read         (avs_read),
    .avs_write        (avs_write),
    .avs_writedata    (avs_writedata),
    .avs_byteenable   (avs_byteenable),
    .avs_readdata     (avs_readdata),
    .avs_waitrequest  (avs_waitrequest),
    .avs_response     (avs_response),
    .sleep_req        (sleep_req),
    .deep_sleep_req   (deep_sleep_req),
    .capability_reg_1 (capability_reg_1),
    .capability_reg_2 (capability_reg_2),
    .capability_reg_4 (capability_reg_4),
    .periph_access    (periph_access),
    .periph_port_sel  (periph_port_sel),
    .periph_fault     (periph_fault),
    .port_clk_en      (port_clk_en),
    .soft_reset_0     (soft_reset_0),
    .soft_reset_1     (soft_reset_1),
    .soft_reset_2     (soft_reset_2),
    .irq              (irq)
  );
  initial forever #20 sys_clk = ~sys_clk;
  task give_verdict;
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk)
    if (++cyc == 4000)
    begin
      miscompares++;
      give_verdict;
    end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask
  // Held until waitrequest is low at a rising edge; the answer is taken
  // there, and the falling edge after lets the write land before checks
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(negedge sys_clk);
  endtask
  task t_reset;
    chk({24'h0, port_clk_en}, 32'h0);
    chk(soft_reset_0 | soft_reset_1 | soft_reset_2, 32'h0);
    bus(1'h0, `PCG_OFS_DSL_GATE, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_src;
    logic [11:0] ofs [3];
    logic [31:0] msk [3];
    ofs = '{`PCG_OFS_SRC0, `PCG_OFS_SRC1, `PCG_OFS_SRC2};
    msk = '{`PCG_SRC0_MASK, `PCG_SRC1_MASK, `PCG_SRC2_MASK};
    foreach (ofs[i])
    begin
      bus(1'h1, ofs[i], 32'hffffffff);
      bus(1'h0, ofs[i], 32'h0);
      chk(rd, msk[i]);
    end
    chk(soft_reset_1, `PCG_SRC1_MASK);
    @(posedge sys_clk);
    capability_reg_1 <= 32'h01000000;
    bus(1'h1, `PCG_OFS_SRC0, 32'h0);
    chk(soft_reset_0, 32'h8);
    @(posedge sys_clk);
    capability_reg_1 <= 32'hffffffff;
    bus(1'h1, `PCG_OFS_SRC0, 32'h0);
    chk(soft_reset_0, 32'h0);
  endtask
  // Frozen clock enable stalls a write, which then lands on lane 0 only
  task t_stall;
    @(posedge sys_clk);
    clk_en <= 1'h0;
    avs_byteenable <= 4'h1;
    avs_address <= `PCG_OFS_SRC1;
    avs_writedata <= 32'h0;
    avs_write <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, avs_waitrequest}, 32'h1);
    chk(soft_reset_1, `PCG_SRC1_MASK);
    clk_en <= 1'h1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
    avs_write <= 1'h0;
    avs_byteenable <= 4'hf;
    @(negedge sys_clk);
    chk(soft_reset_1, `PCG_SRC1_MASK & 32'hffffff00);
  endtask
  task t_gate;
    bus(1'h1, `PCG_OFS_RUN_GATE, 32'hffffff05);
    chk({24'h0, port_clk_en}, 32'h5);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge sys_clk);
      periph_port_sel <= 3'(p);
      periph_access <= 1'h1;
      @(posedge sys_clk);
      periph_access <= 1'h0;
      @(negedge sys_clk);
      chk({31'h0, periph_fault}, 32'(p));
    end
    bus(1'h0, `PCG_OFS_FAULT_ADR, 32'h0);
    chk(rd, 32'h1);
    chk({30'h0, rsp}, 32'h0);
    bus(1'h0, `PCG_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    bus(1'h1, `PCG_OFS_IRQ_MASK, 32'h3);
    chk({31'h0, irq}, 32'h1);
    bus(1'h1, `PCG_OFS_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    bus(1'h0, 12'h0fc, 32'h0);
    chk({rsp, rd[29:0]}, 32'hc0000000);
    chk({31'h0, irq}, 32'h1);
  endtask
  task t_sleep;
    bus(1'h1, `PCG_OFS_RUN_GATE, 32'h0f);
    bus(1'h1, `PCG_OFS_SLP_GATE, 32'h30);
    bus(1'h1, `PCG_OFS_DSL_GATE, 32'hffffffc0);
    bus(1'h0, `PCG_OFS_DSL_GATE, 32'h0);
    chk(rd, 32'hc0);
    @(posedge sys_clk);
    sleep_req <= 1'h1;
    repeat (5) @(negedge sys_clk);
    chk({24'h0, port_clk_en}, 32'h0f);
    bus(1'h0, `PCG_OFS_RUN_CFG, 32'h0);
    bus(1'h1, `PCG_OFS_RUN_CFG, rd | (32'h1 << `PCG_AUTO_GATE_BIT));
    chk({24'h0, port_clk_en}, 32'h30);
    @(posedge sys_clk);
    deep_sleep_req <= 1'h1;
    repeat (5) @(negedge sys_clk);
    chk({24'h0, port_clk_en}, 32'hc0);
    @(posedge sys_clk);
    sleep_req <= 1'h0;
    deep_sleep_req <= 1'h0;
    repeat (5) @(negedge sys_clk);
    chk({24'h0, port_clk_en}, 32'h0f);
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_reset;
    t_src;
    t_stall;
    t_gate;
    t_sleep;
    give_verdict;
  end
endmodule
